// ### hdl/boot_ctl_pkg.sv
package boot_ctl_pkg;
    // ****************************************
    // Clock and reset timing
    // ****************************************
    localparam int CLK_HZ            = 50_000_000;
    localparam int CORE_MULT         = 2;          // Core cycle is twice the input rate
    localparam int PLL_LOCK_CYCLES   = 2000;       // Least reset hold at power-up
    localparam int POR_CNT_W         = 12;
    // ****************************************
    // Strap field positions
    // ****************************************
    localparam int STRAP_W           = 3;
    localparam int STRAP_A           = 0;
    localparam int STRAP_B           = 1;
    localparam int STRAP_C           = 2;
    localparam logic [2:0] STRAP_FULL_BYTE = 3'h0;
    localparam logic [2:0] STRAP_NO_BOOT   = 3'h2;
    localparam logic [2:0] STRAP_HOST_BYTE = 3'h4;
    localparam logic [2:0] STRAP_HOST_PORT = 3'h5;
    // ****************************************
    // Boot loading
    // ****************************************
    localparam int BOOT_WORDS        = 32;
    localparam int WORD_CNT_W        = 6;
    localparam logic [13:0] START_ADDR    = 14'h0000;
    localparam logic [13:0] HOST_GO_ADDR  = 14'h0000;
    localparam int ADDR_W            = 14;
    localparam int STACK_PTR_W       = 4;
    localparam logic [3:0]  STACK_EMPTY   = 4'h0;
    localparam logic [15:0] IMASK_RESET   = 16'h0000;
    localparam logic [7:0]  MODE_STATUS_REG_RESET   = 8'h00;
    // ****************************************
    // Avalon register map of the controller
    // ****************************************
    localparam logic [3:0] REG_CTRL   = 4'h0;  // bit0 reset request, bit1 stored but unused (CLOCK_OUT_DISABLE is a device input), bit2 bus request
    localparam logic [3:0] REG_STRAP  = 4'h4;  // bits 3:0 strap drive values
    localparam logic [3:0] REG_STATUS = 4'h8;  // reset out, run, power-up count done, host write pending
    localparam logic [3:0] REG_HOSTW  = 4'hC;  // host write: [13:0] addr, [16] pm space
    localparam int CTRL_RST    = 0;
    localparam int CTRL_CKDIS  = 1;
    localparam int CTRL_BUSREQ = 2;

    typedef enum logic [2:0] {
        ST_RESET     = 3'b000,
        ST_DECIDE    = 3'b001,
        ST_BYTE_BOOT = 3'b010,
        ST_HOST_BOOT = 3'b011,
        ST_RUN       = 3'b100
    } boot_state_t;
endpackage : boot_ctl_pkg

// ### hdl/boot_link_if.sv
`timescale 1ns/100ps
interface boot_link_if;
    logic              reset_n;         // Board reset to device, active low
    logic              ext_clock_in;    // Input clock toward device
    logic [3:0]        strap_drv;       // Strap values A,B,C,D driven in reset
    logic              strap_oe;        // Strap drivers enabled
    logic              flag_pin_two_o;  // Device drive of shared flag pin
    logic              flag_pin_two_oe;
    logic              bus_req;         // Pending bus request
    logic              host_wr;         // Host port write strobe
    logic [13:0]       host_addr;
    logic              host_pm;         // Host targets program memory
    logic              host_port_ack_o; // Device ack drive level
    logic              host_port_ack_oe;
    logic              core_clock_out;
    logic              byte_word_done;  // Byte loader moved one word
    logic              exec_run;        // Device executes
    wire  [3:0]        strap_seen = strap_oe ? strap_drv : 4'h0;
    wire               flag_level = flag_pin_two_oe ? flag_pin_two_o : strap_seen[2];

    modport device (input reset_n, ext_clock_in, strap_seen, flag_level, bus_req, host_wr,
                    host_addr, host_pm, byte_word_done,
                    output flag_pin_two_o, flag_pin_two_oe, host_port_ack_o,
                    host_port_ack_oe, core_clock_out, exec_run);
    modport host (output reset_n, ext_clock_in, strap_drv, strap_oe, bus_req, host_wr,
                  host_addr, host_pm, byte_word_done,
                  input core_clock_out, exec_run, host_port_ack_o, host_port_ack_oe);
endinterface : boot_link_if

// ### hdl/boot_device.sv
// Decided for this implementation: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/100ps
// Functional notes
// (R1) Input clock doubled for processor cycle
// (R2) Input clock never stops outside power-down
// (R3) Clock output gated by disable bit
// (R4) Power-up reset held 2000 input cycles
// (R5) Later resets need no clock settling
// (R6) Reset empties stacks, masks, clears status
// (R7) Boot only without bus request, booting strap
// (R8) First fetch from address zero
// (R9) Byte boot loads 32 words first
// (R10) Strap 010: no boot, external zero
// (R11) Host boot waits for PM zero write
// (R12) Memory mode sampled from flag pin
// (R13) Strap driver released after reset
// (R14) Ack strap chooses driven or open-drain
// (R15) Straps latched at reset release, held
module boot_device
    import boot_ctl_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       CLOCK_OUT_DISABLE,
    input  wire logic       ACK_REQ,
    boot_link_if.device     LINK,
    output logic [3:0]      STRAP_LATCHED,
    output logic            HOST_MODE,
    output logic            BOOTING,
    output logic [13:0]     FETCH_ADDR,
    output logic            FETCH_EXTERNAL,
    output logic [3:0]      STACK_PTR,
    output logic [15:0]     INT_MASK,
    output logic [7:0]      MODE_STATUS
);
    // ****************************************
    // Input synchronisers, three stages
    // ****************************************
    logic [2:0] rst_s, clk_s, wr_s, wd_s;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rst_s <= 3'h0;
            clk_s <= 3'h0;
            wr_s  <= 3'h0;
            wd_s  <= 3'h0;
        end else begin
            rst_s <= {rst_s[1:0], LINK.reset_n};
            clk_s <= {clk_s[1:0], LINK.ext_clock_in};
            wr_s  <= {wr_s[1:0],  LINK.host_wr};
            wd_s  <= {wd_s[1:0],  LINK.byte_word_done};
        end
    end
    // Change counted only when stages two and three agree
    logic rst_n_q, ext_clock_in_q, wr_q, wd_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            rst_n_q <= 1'b0;
            ext_clock_in_q <= 1'b0;
            wr_q    <= 1'b0;
            wd_q    <= 1'b0;
        end else begin
            if (rst_s[2] == rst_s[1]) rst_n_q <= rst_s[2];
            if (clk_s[2] == clk_s[1]) ext_clock_in_q <= clk_s[2];
            if (wr_s[2] == wr_s[1])   wr_q    <= wr_s[2];
            if (wd_s[2] == wd_s[1])   wd_q    <= wd_s[2];
        end
    end
    logic ext_clock_in_d1_q, wr_d1_q, wd_d1_q, rst_n_d1_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ext_clock_in_d1_q <= 1'b0;
            wr_d1_q    <= 1'b0;
            wd_d1_q    <= 1'b0;
            rst_n_d1_q <= 1'b0;
        end else begin
            ext_clock_in_d1_q <= ext_clock_in_q;
            wr_d1_q    <= wr_q;
            wd_d1_q    <= wd_q;
            rst_n_d1_q <= rst_n_q;
        end
    end
    wire ext_clock_in_edge = ext_clock_in_q ^ ext_clock_in_d1_q;   // Both edges give two core ticks (R1)
    wire wr_rise    = wr_q & ~wr_d1_q;
    wire wd_rise    = wd_q & ~wd_d1_q;
    wire release_ev = rst_n_q & ~rst_n_d1_q;
    // ****************************************
    // Core clock output
    // ****************************************
    // Toggles on every input edge and again one cycle later, giving twice
    // the input rate; needs an input half period of at least two cycles
    logic core_ck_q;
    logic mid_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) mid_q <= 1'b0;
        else mid_q <= ext_clock_in_edge;
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) core_ck_q <= 1'b0;
        else if (ext_clock_in_edge || mid_q) core_ck_q <= ~core_ck_q; // (R1)
    end
    assign LINK.core_clock_out = core_ck_q & ~CLOCK_OUT_DISABLE; // (R3)
    // Clock keeps running through later resets (R5)
    // ****************************************
    // Strap capture
    // ****************************************
    // Sampled while the reset pin is low; frozen at release (R15)
    // Raw pin level on purpose: strap drivers let go the moment reset rises,
    // so the synchronised reset would capture released straps
    logic [3:0] strap_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) strap_q <= 4'h0;
        else if (!LINK.reset_n) strap_q <= {LINK.strap_seen[3], LINK.flag_level,
                                       LINK.strap_seen[1:0]}; // (R12) (R15)
    end
    assign STRAP_LATCHED = strap_q;
    wire [2:0] mode_abc = strap_q[2:0];
    assign HOST_MODE = strap_q[STRAP_C]; // (R11) (R14)
    // Flag pin left undriven by device; driver releases after reset (R13)
    assign LINK.flag_pin_two_o  = 1'b0;
    assign LINK.flag_pin_two_oe = 1'b0;
    // ****************************************
    // Boot sequencer
    // ****************************************
    boot_state_t st_q;
    logic [WORD_CNT_W-1:0] words_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st_q <= ST_RESET;
        end else if (!rst_n_q) begin
            st_q <= ST_RESET;
        end else begin
            case (st_q)
                ST_RESET: begin
                    if (release_ev) st_q <= ST_DECIDE;
                end
                ST_DECIDE: begin
                    if (LINK.bus_req || mode_abc == STRAP_NO_BOOT) st_q <= ST_RUN; // (R7) (R10)
                    else if (mode_abc == STRAP_FULL_BYTE || mode_abc == STRAP_HOST_BYTE)
                        st_q <= ST_BYTE_BOOT; // (R9)
                    else if (mode_abc == STRAP_HOST_PORT) st_q <= ST_HOST_BOOT; // (R11)
                    else st_q <= ST_RUN;
                end
                ST_BYTE_BOOT: begin
                    if (wd_rise && words_q == WORD_CNT_W'(BOOT_WORDS - 1)) st_q <= ST_RUN; // (R9)
                end
                ST_HOST_BOOT: begin
                    if (wr_rise && LINK.host_pm && LINK.host_addr == HOST_GO_ADDR)
                        st_q <= ST_RUN; // (R11)
                end
                default: st_q <= st_q;
            endcase
        end
    end
    // Word counter of the byte loader
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) words_q <= '0;
        else if (st_q != ST_BYTE_BOOT) words_q <= '0;
        else if (wd_rise) words_q <= words_q + 1'b1; // (R9)
    end
    assign BOOTING       = (st_q == ST_BYTE_BOOT) || (st_q == ST_HOST_BOOT);
    assign LINK.exec_run = (st_q == ST_RUN);
    // First fetch address; no-boot mode runs from external memory
    logic ext_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) ext_q <= 1'b0;
        else if (st_q == ST_DECIDE) ext_q <= (mode_abc == STRAP_NO_BOOT); // (R10)
    end
    assign FETCH_ADDR     = START_ADDR; // (R8)
    assign FETCH_EXTERNAL = ext_q;
    // ****************************************
    // Master reset state
    // ****************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            STACK_PTR   <= STACK_EMPTY;
            INT_MASK    <= IMASK_RESET;
            MODE_STATUS <= MODE_STATUS_REG_RESET;
        end else if (!rst_n_q) begin
            STACK_PTR   <= STACK_EMPTY;  // (R6)
            INT_MASK    <= IMASK_RESET;  // (R6)
            MODE_STATUS <= MODE_STATUS_REG_RESET;  // (R6)
        end
    end
    // ****************************************
    // Host acknowledge pin
    // ****************************************
    // Open-drain form only ever pulls low; pull-up is board side
    logic ack_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) ack_q <= 1'b0;
        else ack_q <= ACK_REQ & HOST_MODE;
    end
    assign LINK.host_port_ack_o  = strap_q[3] ? 1'b0 : ~ack_q;         // (R14)
    assign LINK.host_port_ack_oe = HOST_MODE & (strap_q[3] ? ack_q : 1'b1); // (R14)
endmodule : boot_device

// ### hdl/boot_host.sv
`timescale 1ns/100ps
module boot_host
    import boot_ctl_pkg::*;
#(
    parameter int LOCK_CYCLES = PLL_LOCK_CYCLES
)(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    boot_link_if.host        LINK
);
    // ****************************************
    // Register file
    // ****************************************
    logic [2:0]  ctrl_q;
    logic [3:0]  strap_q;
    logic [16:0] hw_q;
    logic        hw_pend_q, ack_q;
    logic [POR_CNT_W-1:0] por_q;
    // Waitrequest low for one cycle per request; one-cycle latency
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) ack_q <= 1'b0;
        else ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
    end
    assign AVS_WAITREQUEST = ~ack_q;
    wire wr_ok = AVS_WRITE & ack_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q  <= 3'h1;
            strap_q <= 4'h0;
            hw_q    <= 17'h00000;
        end else if (wr_ok) begin
            if (AVS_ADDRESS == REG_CTRL) ctrl_q <= AVS_WRITEDATA[2:0];
            else if (AVS_ADDRESS == REG_STRAP) strap_q <= AVS_WRITEDATA[3:0];
            else if (AVS_ADDRESS == REG_HOSTW) hw_q <= AVS_WRITEDATA[16:0];
        end
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) AVS_READDATA <= 32'h00000000;
        else if (AVS_ADDRESS == REG_CTRL) AVS_READDATA <= {29'h0, ctrl_q};
        else if (AVS_ADDRESS == REG_STRAP) AVS_READDATA <= {28'h0, strap_q};
        else if (AVS_ADDRESS == REG_STATUS)
            AVS_READDATA <= {28'h0, hw_pend_q, por_q == '0, LINK.exec_run, LINK.reset_n};
        else if (AVS_ADDRESS == REG_HOSTW) AVS_READDATA <= {15'h0, hw_q};
        else AVS_READDATA <= 32'h00000000;
    end
    // ****************************************
    // Power-up reset hold
    // ****************************************
    // Counts input clock periods; reset low until count done (R4)
    // Input clock at a quarter of CLK so the device can double it
    logic [1:0] div_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) div_q <= 2'h0;
        else div_q <= div_q + 2'h1;   // Steady input clock, never stopped (R2)
    end
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) por_q <= POR_CNT_W'(LOCK_CYCLES);
        else if (div_q == 2'h3 && por_q != '0) por_q <= por_q - 1'b1; // (R4)
    end
    assign LINK.ext_clock_in = div_q[1];
    assign LINK.reset_n  = (por_q == '0) & ~ctrl_q[CTRL_RST];
    // Strap drivers enabled only in reset (R13)
    assign LINK.strap_drv = strap_q;
    assign LINK.strap_oe  = ~LINK.reset_n; // (R13)
    assign LINK.bus_req   = ctrl_q[CTRL_BUSREQ];
    // ****************************************
    // Host write pulse and byte loader words
    // ****************************************
    // Write strobe stretched to four cycles to pass device synchronisers
    logic [1:0] hw_cnt_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            hw_pend_q <= 1'b0;
            hw_cnt_q  <= 2'h0;
        end else if (wr_ok && AVS_ADDRESS == REG_HOSTW) begin
            hw_pend_q <= 1'b1;
            hw_cnt_q  <= 2'h3;
        end else if (hw_cnt_q != 2'h0) begin
            hw_cnt_q <= hw_cnt_q - 1'b1;
        end else begin
            hw_pend_q <= 1'b0;
        end
    end
    assign LINK.host_wr   = hw_pend_q; // (R11)
    assign LINK.host_addr = hw_q[13:0];
    assign LINK.host_pm   = hw_q[16];
    // Byte loader word ticks every eight cycles while not running
    logic [2:0] bw_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) bw_q <= 3'h0;
        else if (!LINK.reset_n) bw_q <= 3'h0; // No tick before the device decides
        else bw_q <= bw_q + 1'b1;
    end
    assign LINK.byte_word_done = LINK.reset_n & ~LINK.exec_run & bw_q[2];
endmodule : boot_host

// ### verification/boot_link_assertions.sv
`timescale 1ns/100ps
module boot_link_assertions #(
    parameter int LOCK_CYCLES = 8
)(
    input wire logic CLK,
    input wire logic RST,
    input wire logic reset_n,
    input wire logic ext_clock_in,
    input wire logic strap_oe,
    input wire logic flag_pin_two_oe,
    input wire logic host_wr,
    input wire logic exec_run
);
    // **********************
    // Helper count
    // **********************
    // Cycles since RST; later resets never fall below the lock figure
    logic [31:0] cyc_q;
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            cyc_q <= 32'h0;
        end else begin
            cyc_q <= cyc_q + 32'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // Host write strobe shape
    sequence host_pulse_s;
        host_wr [*4] ##1 !host_wr;
    endsequence
    a_lock_hold: assert property ($rose(reset_n) |-> cyc_q >= 32'(4 * LOCK_CYCLES))
        else $error("board reset released before lock time");
    a_ext_clock_in_toggle: assert property ($past(RST, 2) || ext_clock_in != $past(ext_clock_in, 2))
        else $error("input clock stalled");
    a_strap_release: assert property (reset_n |-> !strap_oe)
        else $error("strap driver active after reset");
    a_no_run_reset: assert property (!reset_n [*6] |-> !exec_run)
        else $error("execution during reset");
    a_boot_delay: assert property ($rose(reset_n) |-> !exec_run [*3])
        else $error("execution right at reset release");
    a_flag_free: assert property (!reset_n |-> !flag_pin_two_oe)
        else $error("flag pin driven during reset");
    a_host_pulse: assert property ($rose(host_wr) |-> host_pulse_s)
        else $error("host write strobe length wrong");
    a_run_holds: assert property (exec_run && reset_n |=> exec_run)
        else $error("execution stopped without reset");
endmodule : boot_link_assertions

// ### verification/tb_top.sv
`timescale 1ns/100ps
module tb_top;
    import boot_ctl_pkg::*;
    logic        clk;
    logic        rst;
    logic        ck_dis;
    logic        ack_req;
    logic [3:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wdata;
    logic [31:0] av_rdata;
    logic        av_wait;
    logic [3:0]  strap_lat;
    logic        host_mode;
    logic        booting;
    logic [13:0] fetch_addr;
    logic        fetch_ext;
    logic [3:0]  stack_ptr;
    logic [15:0] int_mask;
    logic [7:0]  mode_stat;
    logic [31:0] q;
    logic [3:0]  s;
    logic [3:0]  straps [5] = '{4'h0, 4'h2, 4'h4, 4'h5, 4'hD};
    int          err_total;
    int          check_count;
    int          words;
    int          edges;
    int          boot_seen;

    boot_link_if boot_link_if_i ();
    boot_host #(.LOCK_CYCLES(8)) boot_host_i (.CLK(clk), .RST(rst), .AVS_ADDRESS(av_addr),
        .AVS_READ(av_rd), .AVS_WRITE(av_wr), .AVS_WRITEDATA(av_wdata),
        .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .LINK(boot_link_if_i));
    boot_device boot_device_i (.CLK(clk), .RST(rst), .CLOCK_OUT_DISABLE(ck_dis),
        .ACK_REQ(ack_req), .LINK(boot_link_if_i), .STRAP_LATCHED(strap_lat),
        .HOST_MODE(host_mode), .BOOTING(booting), .FETCH_ADDR(fetch_addr),
        .FETCH_EXTERNAL(fetch_ext), .STACK_PTR(stack_ptr), .INT_MASK(int_mask),
        .MODE_STATUS(mode_stat));
    boot_link_assertions #(.LOCK_CYCLES(8)) boot_link_assertions_i (.CLK(clk), .RST(rst),
        .reset_n(boot_link_if_i.reset_n), .ext_clock_in(boot_link_if_i.ext_clock_in),
        .strap_oe(boot_link_if_i.strap_oe), .flag_pin_two_oe(boot_link_if_i.flag_pin_two_oe),
        .host_wr(boot_link_if_i.host_wr), .exec_run(boot_link_if_i.exec_run));

    always #10 clk = ~clk;
    // Event counters; edge count catches a clock output faster than our sampling
    always @(posedge boot_link_if_i.byte_word_done) words++;
    always @(boot_link_if_i.core_clock_out) edges++;
    always @(posedge booting) boot_seen++;

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Request held until the edge that sees waitrequest low
    task automatic av_xfer(input logic [3:0] a, input logic wr, input logic [31:0] d);
        int   n;
        logic w;
        n = 0;
        av_addr  <= a;
        av_wr    <= wr;
        av_rd    <= !wr;
        av_wdata <= d;
        do begin
            @(posedge clk);
            w = av_wait;
            q = av_rdata;
            n++;
        end while (w !== 1'b0 && n < 50);
        if (w !== 1'b0) begin
            chk(0, 1, "bus timeout");
            report_and_stop();
        end
        av_wr <= 1'b0;
        av_rd <= 1'b0;
        @(posedge clk);
    endtask : av_xfer

    task automatic wait_run(input int lim);
        int n;
        n = 0;
        while (boot_link_if_i.exec_run !== 1'b1 && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            chk(0, 1, "run timeout");
            report_and_stop();
        end
    endtask : wait_run

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        ck_dis = 1'b0;
        ack_req = 1'b0;
        av_addr = 4'h0;
        av_rd = 1'b0;
        av_wr = 1'b0;
        av_wdata = 32'h0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        av_xfer(REG_CTRL, 1'b0, 32'h0);
        chk(q[0], 1'b1, "ctrl reset value");
        av_xfer(4'h2, 1'b0, 32'h0);
        chk(q, 32'h0, "unmapped read");
        // **********************
        // Every boot strap in turn
        // **********************
        foreach (straps[i]) begin
            s = straps[i];
            av_xfer(REG_CTRL, 1'b1, 32'h1);
            av_xfer(REG_STRAP, 1'b1, {28'h0, s});
            repeat (8) @(posedge clk);
            chk({stack_ptr, int_mask, mode_stat}, {STACK_EMPTY, IMASK_RESET, MODE_STATUS_REG_RESET}, "clr");
            words = 0;
            boot_seen = 0;
            av_xfer(REG_CTRL, 1'b1, 32'h0);
            if (s[0]) begin
                repeat (40) @(posedge clk);
                chk(boot_link_if_i.exec_run, 0, "held for host");
                av_xfer(REG_HOSTW, 1'b1, 32'h0001_0005);
                repeat (6) @(posedge clk);
                av_xfer(REG_HOSTW, 1'b1, 32'h0000_0000);
                repeat (10) @(posedge clk);
                chk(boot_link_if_i.exec_run, 0, "held after other writes");
                av_xfer(REG_HOSTW, 1'b1, 32'h0001_0000);
            end
            wait_run(400);
            if (!s[0] && !s[1]) chk(words, 32, "byte words");
            chk(boot_seen, s[1] ? 0 : 1, "boot phase");
            chk(fetch_ext, s[2:0] == STRAP_NO_BOOT, "external start");
            chk(host_mode, s[2], "memory mode");
            chk(fetch_addr, START_ADDR, "first fetch");
            if (s[2]) begin
                chk(boot_link_if_i.host_port_ack_oe, !s[3], "ack drive");
                ack_req <= 1'b1;
                repeat (3) @(posedge clk);
                chk({boot_link_if_i.host_port_ack_oe, boot_link_if_i.host_port_ack_o}, 2'b10, "ack asserted");
                ack_req <= 1'b0;
            end
            av_xfer(REG_STRAP, 1'b1, {28'h0, ~s});
            repeat (4) @(posedge clk);
            chk(strap_lat, s, "latched straps");
            av_xfer(REG_STATUS, 1'b0, 32'h0);
            chk(q[2:0], 3'h7, "status");
            $display("test strap %h done", s);
        end
        // Clock output gating
        ck_dis <= 1'b1;
        repeat (2) @(posedge clk);
        edges = 0;
        repeat (8) @(posedge clk);
        chk(edges, 0, "clock out gated");
        ck_dis <= 1'b0;
        repeat (2) @(posedge clk);
        edges = 0;
        repeat (8) @(posedge clk);
        chk(edges > 4, 1, "clock out running");
        $display("test clock output done");
        // Pending bus request skips the boot, no settling wait
        av_xfer(REG_CTRL, 1'b1, 32'h5);
        av_xfer(REG_STRAP, 1'b1, 32'h0);
        repeat (8) @(posedge clk);
        boot_seen = 0;
        av_xfer(REG_CTRL, 1'b1, 32'h4);
        wait_run(60);
        chk(boot_seen, 0, "boot skipped");
        $display("test bus request done");
        report_and_stop();
    end
endmodule : tb_top
